// file: design/input_macro_decoder.v
// Drive input macro decoder: digital terminals to run, direction and reference commands.
`timescale 1ns/100ps
`include "input_macro_regs.vh"

module input_macro_decoder #(
  parameter FILTER_CYCLES = `FILTER_CYCLES
) (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       digital_in_one,
  input  wire       digital_in_two,
  input  wire       digital_in_three,
  input  wire       digital_in_four,
  input  wire [3:0] control_source,
  input  wire [4:0] input_macro,
  input  wire       analog_two_format,
  input  wire       keypad_start_needed,
  input  wire       keypad_start_key,
  input  wire       keypad_stop_key,
  input  wire       fieldbus_start,
  input  wire       fieldbus_stop,
  input  wire       auto_start,
  input  wire       trip_reset,
  output reg        run_ff,
  output reg        reverse_ff,
  output reg        fast_stop_ff,
  output reg  [2:0] ref_select_ff,
  output reg  [1:0] preset_index_ff,
  output reg        speed_up_input_ff,
  output reg        speed_down_input_ff,
  output reg        ext_trip_ff,
  output reg        ext_trip_code_a_ff,
  output reg        ext_trip_code_b_ff,
  output reg        hw_enable_ff
);

  // ****************************************
  // Input synchronisers and filters
  // ****************************************
  reg  [3:0]  sync1_ff;
  reg  [3:0]  sync2_ff;
  wire [3:0]  din_lvl;
  reg  [31:0] settle_cnt_ff;
  reg         powered_ff;
  reg         auto_done_ff;
  wire [3:0]  raw_in;
  wire [3:0]  din_prev;

  assign raw_in = {digital_in_four, digital_in_three, digital_in_two, digital_in_one};

  // Two flops before anything reads a terminal, since contacts are asynchronous.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Each terminal is debounced; a contact must hold its level for the whole filter time.
  // This trades a millisecond of latency for immunity to contact bounce.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
      reg [31:0] stable_cnt_ff;
      reg        din_ff;
      assign din_lvl[gi] = din_ff;
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          stable_cnt_ff <= 32'h0;
          din_ff        <= 1'b0;
        end else if (sync2_ff[gi] == din_ff) begin
          stable_cnt_ff <= 32'h0;
        end else if (stable_cnt_ff >= FILTER_CYCLES - 1) begin
          stable_cnt_ff <= 32'h0;
          din_ff        <= sync2_ff[gi];
        end else begin
          stable_cnt_ff <= stable_cnt_ff + 32'h1;
        end
      end
    end
  endgenerate

  // The filters restart from open after reset, so a closed trip or stop contact
  // would look like an opening; run and the trip latch stay held off until the filters caught up.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      settle_cnt_ff <= 32'h0;
      powered_ff    <= 1'b0;
    end else if (!powered_ff) begin
      if (settle_cnt_ff >= FILTER_CYCLES + `SETTLE_EXTRA - 1) begin
        powered_ff <= 1'b1;
      end else begin
        settle_cnt_ff <= settle_cnt_ff + 32'h1;
      end
    end
  end

  // Previous filtered levels for edge detection.
  reg [3:0] prev_ff;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_ff <= 4'h0;
    end else begin
      prev_ff <= din_lvl;
    end
  end
  assign din_prev = prev_ff;

  wire d1 = din_lvl[0];
  wire d2 = din_lvl[1];
  wire d3 = din_lvl[2];
  wire d4 = din_lvl[3];
  wire rise1 = d1 & ~din_prev[0];
  wire rise3 = d3 & ~din_prev[2];
  wire rise4 = d4 & ~din_prev[3];
  wire fall2 = ~d2 & din_prev[1];

  // ****************************************
  // Macro decode
  // ****************************************
  reg       nxt_run;
  reg       nxt_reverse;
  reg       nxt_fast_stop;
  reg [2:0] nxt_ref;
  reg [1:0] nxt_preset;
  reg       nxt_up;
  reg       nxt_down;
  reg       nxt_trip_in;
  reg       nxt_enable;
  reg       start_pulse;
  reg       start_rev;
  reg       stop_pulse;
  reg       latched_mode;
  wire      terminal_mode = (control_source == `SRC_TERMINAL);
  wire      keypad_mode   = (control_source == `SRC_KEYPAD_A) || (control_source == `SRC_KEYPAD_B);

  always @* begin
    nxt_run       = 1'b0;
    nxt_reverse   = reverse_ff;
    nxt_fast_stop = 1'b0;
    nxt_ref       = `REF_ANALOG1;
    nxt_preset    = 2'h0;
    nxt_up        = 1'b0;
    nxt_down      = 1'b0;
    nxt_trip_in   = 1'b1;
    nxt_enable    = 1'b0;
    start_pulse   = 1'b0;
    start_rev     = 1'b0;
    stop_pulse    = 1'b0;
    latched_mode  = 1'b1;
    if (terminal_mode) begin
      nxt_run = d1;
      case (input_macro)
        5'h00: begin
          nxt_reverse = d2;
          nxt_ref     = d3 ? `REF_PRESET : `REF_ANALOG1;
        end
        5'h01: begin
          nxt_ref    = d2 ? `REF_PRESET : `REF_ANALOG1;
          nxt_preset = {1'b0, d3};
        end
        5'h02: begin
          nxt_preset = {d3, d2};
          nxt_ref    = d4 ? `REF_ANALOG1 : `REF_PRESET;
        end
        5'h03, 5'h06: begin
          nxt_trip_in = d3;
          if (input_macro == 5'h06) begin
            nxt_reverse = d2;
          end else begin
            nxt_ref = d2 ? `REF_PRESET : `REF_ANALOG1;
          end
        end
        5'h04: begin
          nxt_ref = d2 ? `REF_ANALOG2 : `REF_ANALOG1;
        end
        5'h05, 5'h07: begin
          nxt_fast_stop = d1 & d2;
          nxt_run       = (d1 ^ d2);
          nxt_reverse   = d2 & ~d1;
          if (input_macro == 5'h07) begin
            nxt_trip_in = d3;
          end else begin
            nxt_ref = d3 ? `REF_PRESET : `REF_ANALOG1;
          end
        end
        5'h08: begin
          nxt_reverse = d2;
          nxt_preset  = {d4, d3};
          nxt_ref     = `REF_PRESET;
        end
        5'h09: begin
          latched_mode = 1'b0;
          start_pulse  = rise1 | rise3;
          start_rev    = rise3 & ~rise1;
          stop_pulse   = fall2;
          nxt_preset   = {d4, 1'b0};
          nxt_ref      = `REF_PRESET;
          nxt_fast_stop = d1 & d3;
        end
        default: begin
          nxt_ref = `REF_ANALOG1;
        end
      endcase
    end else begin
      // The first terminal is both the stop contact and the hardware enable here.
      nxt_enable = d1;
      if (keypad_mode) begin
        nxt_run = d1;
        case (input_macro)
          5'h00, 5'h02: begin
            nxt_up   = d2;
            nxt_down = d3;
            if (input_macro == 5'h00) begin
              nxt_reverse = d4;
              nxt_ref     = `REF_KEYPAD;
            end else begin
              nxt_ref     = d4 ? `REF_PRESET : `REF_KEYPAD;
            end
          end
          5'h06: begin
            nxt_reverse = d2;
            nxt_trip_in = d3;
            nxt_ref     = d4 ? `REF_PRESET : `REF_KEYPAD;
          end
          default: begin
            nxt_ref = `REF_KEYPAD;
          end
        endcase
      end else begin
        nxt_run = d1;
        nxt_ref = `REF_FIELDBUS;
        case (input_macro)
          5'h03: begin
            nxt_ref     = d2 ? `REF_PRESET : `REF_FIELDBUS;
            nxt_trip_in = d3;
          end
          5'h05: begin
            nxt_ref    = d2 ? `REF_PRESET : `REF_FIELDBUS;
            nxt_preset = {1'b0, d3};
          end
          5'h06: begin
            nxt_ref     = d2 ? `REF_ANALOG1 : `REF_FIELDBUS;
            nxt_trip_in = d3;
          end
          5'h07: begin
            nxt_ref     = d2 ? `REF_KEYPAD : `REF_FIELDBUS;
            nxt_trip_in = d3;
          end
          default: begin
            nxt_ref = `REF_FIELDBUS;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Run state and trip latch
  // ****************************************
  reg run_state_ff;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_state_ff        <= 1'b0;
      run_ff              <= 1'b0;
      reverse_ff          <= 1'b0;
      fast_stop_ff        <= 1'b0;
      ref_select_ff       <= `REF_ANALOG1;
      preset_index_ff     <= 2'h0;
      speed_up_input_ff   <= 1'b0;
      speed_down_input_ff <= 1'b0;
      ext_trip_ff         <= 1'b0;
      ext_trip_code_a_ff  <= 1'b0;
      ext_trip_code_b_ff  <= 1'b0;
      hw_enable_ff        <= 1'b0;
      auto_done_ff        <= 1'b0;
    end else begin
      fast_stop_ff        <= nxt_fast_stop;
      ref_select_ff       <= nxt_ref;
      preset_index_ff     <= nxt_preset;
      speed_up_input_ff   <= nxt_up;
      speed_down_input_ff <= nxt_down;
      hw_enable_ff        <= nxt_enable;
      if (start_pulse) begin
        reverse_ff <= start_rev;
      end else begin
        reverse_ff <= nxt_reverse;
      end
      // trip latch; a new opening beats a simultaneous reset.
      if (!nxt_trip_in && powered_ff) begin
        ext_trip_ff        <= 1'b1;
        ext_trip_code_a_ff <= ~analog_two_format;
        ext_trip_code_b_ff <= analog_two_format;
      end else if (trip_reset) begin
        ext_trip_ff        <= 1'b0;
        ext_trip_code_a_ff <= 1'b0;
        ext_trip_code_b_ff <= 1'b0;
      end
      if (!powered_ff) begin
        run_state_ff <= 1'b0;
      end else if (terminal_mode) begin
        // auto start; without it a run held at power-on needs a fresh closure.
        if (!auto_done_ff) begin
          auto_done_ff <= 1'b1;
          run_state_ff <= auto_start & nxt_run & latched_mode;
        end else if (!latched_mode) begin
          if (stop_pulse || nxt_fast_stop) begin
            run_state_ff <= 1'b0;
          end else if (start_pulse) begin
            run_state_ff <= 1'b1;
          end
        end else if (!nxt_run) begin
          run_state_ff <= 1'b0;
        end else if (auto_start || rise1 || (d2 & ~din_prev[1])) begin
          run_state_ff <= 1'b1;
        end
      end else if (keypad_mode) begin
        auto_done_ff <= 1'b1;
        if (!nxt_run || !nxt_enable || keypad_stop_key) begin
          run_state_ff <= 1'b0;
        end else if (!keypad_start_needed || keypad_start_key) begin
          run_state_ff <= 1'b1;
        end
      end else begin
        auto_done_ff <= 1'b1;
        if (!nxt_run || !nxt_enable || fieldbus_stop) begin
          run_state_ff <= 1'b0;
        end else if (fieldbus_start) begin
          run_state_ff <= 1'b1;
        end
      end
      run_ff <= run_state_ff & ~ext_trip_ff & ~nxt_fast_stop;
    end
  end

endmodule // input_macro_decoder

// file: design/input_macro_regs.vh
// Constants for the drive input macro decoder.
// What this block does
// - Control-source selector decides the setpoint source; zero means terminal control.
// - Input-macro selector assigns the function of every digital and analogue input.
// - Latched run input runs while closed and stops when opened.
// - Direction input selects forward or reverse rotation from its level.
// - Analogue-input-1 reference function takes speed from analogue input one.
// - Single preset selection uses the chosen preset speed as setpoint.
// - Preset group picks one of four presets from other digital inputs.
// - Both paired run inputs together stop with the fast-stop ramp.
// - Normally closed trip input opening trips; code chosen by analogue-two format.
// - Normally open start input starts on a momentary closure.
// - Normally closed stop input stops on a momentary opening.
// - Keypad mode: keypad-start setting decides enable-alone start or key needed.
// - Outside keypad mode, enable must be present before fieldbus start is accepted.
// - Speed-increase input raises speed while closed.
// - Speed-decrease input lowers speed while closed.
// - Keypad reference selection uses the keypad speed reference.
// - Fieldbus reference selection takes speed from the selected fieldbus.
// - Auto-start setting decides self start after power-on with the run input closed; latched terminal macros only.
`ifndef INPUT_MACRO_REGS_VH
`define INPUT_MACRO_REGS_VH
// ****************************************
// Control source codes
// ****************************************
`define SRC_TERMINAL  4'h0
`define SRC_KEYPAD_A  4'h1
`define SRC_KEYPAD_B  4'h2
// ****************************************
// Speed reference selector codes
// ****************************************
`define REF_ANALOG1   3'h0
`define REF_ANALOG2   3'h1
`define REF_PRESET    3'h2
`define REF_KEYPAD    3'h3
`define REF_FIELDBUS  3'h4
// ****************************************
// Timing
// ****************************************
`define CLK_MHZ       50
`define FILTER_US     1000
`define FILTER_CYCLES (`FILTER_US * `CLK_MHZ)
`define SETTLE_EXTRA  4
`endif

// file: tb/input_macro_checker.sv
// Port-level assertions for the input macro decoder.
`timescale 1ns/100ps
`include "input_macro_regs.vh"
module input_macro_checker #(
  parameter FILTER_CYCLES = 4
) (
  input wire       mclk,
  input wire       rst_b,
  input wire [3:0] control_source,
  input wire [4:0] input_macro,
  input wire       analog_two_format,
  input wire       trip_reset,
  input wire       run_ff,
  input wire       fast_stop_ff,
  input wire [2:0] ref_select_ff,
  input wire       ext_trip_ff,
  input wire       ext_trip_code_a_ff,
  input wire       ext_trip_code_b_ff,
  input wire       hw_enable_ff
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Quiet spans of several cycles keep pipelined selects and clears from false alarms.
  sequence trip_rise_s; $rose(ext_trip_ff); endsequence
  sequence no_clear_s; !trip_reset [*4]; endsequence
  sequence fb_mode_s; control_source > 4'h2 && input_macro == 5'h00; endsequence
  sequence term_mode_s; control_source == `SRC_TERMINAL; endsequence
  a_reset_idle: assert property ($rose(rst_b) |-> !run_ff && !ext_trip_ff && ref_select_ff == 3'h0)
    else $error("outputs not idle after reset");
  a_trip_stops_run: assert property (trip_rise_s |-> ##[0:2] !run_ff)
    else $error("run stayed on after trip");
  a_trip_code_pick: assert property (trip_rise_s |-> ##[0:1]
    (analog_two_format ? ext_trip_code_b_ff : ext_trip_code_a_ff)) else $error("wrong trip code");
  a_trip_holds: assert property (no_clear_s ##0 ext_trip_ff |=> ext_trip_ff)
    else $error("trip dropped without clear");
  a_fb_needs_enable: assert property ($rose(run_ff) && control_source > 4'h2 |->
    hw_enable_ff || $past(hw_enable_ff)) else $error("fieldbus run without enable");
  a_fast_stop_run: assert property ($rose(fast_stop_ff) |-> ##[0:2] !run_ff)
    else $error("fast stop left run on");
  a_fieldbus_reference_sel: assert property (fb_mode_s [*8] |-> ref_select_ff == `REF_FIELDBUS)
    else $error("fieldbus reference not chosen");
  a_term_not_fb: assert property (term_mode_s [*8] |-> ref_select_ff != `REF_FIELDBUS)
    else $error("fieldbus reference in terminal mode");
endmodule // input_macro_checker

// file: tb/terminal_switches.sv
// Contact model for the four control terminals, with one bounce per change.
`timescale 1ns/100ps
module terminal_switches (
  input  wire       mclk,
  input  wire [3:0] want,
  output reg  [3:0] pin
);
  reg [3:0] h1_ff;
  reg [3:0] h2_ff;
  // contact levels.
  // A real contact chatters, so the second edge after a change shows the old level once.
  always @(posedge mclk) begin
    h1_ff <= want;
    h2_ff <= h1_ff;
    pin   <= (h1_ff != h2_ff && want == h1_ff) ? h2_ff : want;
  end
endmodule // terminal_switches

// file: tb/test_input_macro_decoder.sv
// Self-checking bench for the drive input macro decoder.
`timescale 1ns/100ps
`include "input_macro_regs.vh"
module test_input_macro_decoder;
  localparam int FILT = 4;
  logic       mclk, rst_b, fmt, kp_need, kp_go, fb_go, auto_go, trip_clr, kp_halt, fb_halt;
  logic [3:0] src, want;
  logic [4:0] macro;
  wire  [3:0] pin;
  wire        run, rev, fstop, up, down, trip, code_a, code_b, en;
  wire  [2:0] refs;
  wire  [1:0] idx;
  int         err_total, n_compared;
  // ****************************************
  // Clock, partner and design
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  terminal_switches sw_u (.mclk(mclk), .want(want), .pin(pin));
  input_macro_decoder #(.FILTER_CYCLES(FILT)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .digital_in_one(pin[0]), .digital_in_two(pin[1]),
    .digital_in_three(pin[2]), .digital_in_four(pin[3]), .control_source(src), .input_macro(macro),
    .analog_two_format(fmt), .keypad_start_needed(kp_need), .keypad_start_key(kp_go),
    .keypad_stop_key(kp_halt), .fieldbus_start(fb_go), .fieldbus_stop(fb_halt), .auto_start(auto_go),
    .trip_reset(trip_clr), .run_ff(run), .reverse_ff(rev), .fast_stop_ff(fstop), .ref_select_ff(refs),
    .preset_index_ff(idx), .speed_up_input_ff(up), .speed_down_input_ff(down), .ext_trip_ff(trip),
    .ext_trip_code_a_ff(code_a), .ext_trip_code_b_ff(code_b), .hw_enable_ff(en));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits past sync, filter, bounce and output stages; lands just after an edge.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic put(input logic [3:0] w);
    want = w;
    tick(FILT + 12);
  endtask
  task automatic restart(input logic [3:0] s, input logic [4:0] m, input logic [3:0] w);
    rst_b = 1'b0;
    src = s;
    macro = m;
    want = w;
    tick(4);
    rst_b = 1'b1;
    tick(FILT + 12);
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_b, fmt, kp_need, kp_go, fb_go, auto_go, trip_clr, kp_halt, fb_halt} = 9'h000;
    {src, want, macro, err_total, n_compared} = '0;
    restart(`SRC_TERMINAL, 5'h00, 4'h0);
    put(4'h1); chk(run, 1); chk(rev, 0);
    chk(refs, `REF_ANALOG1);
    put(4'h3); chk(rev, 1);
    put(4'h7); chk(refs, `REF_PRESET); chk(idx, 0);
    put(4'h6); chk(run, 0);
    // Every two-input preset code in turn.
    restart(`SRC_TERMINAL, 5'h02, 4'h0);
    for (int k = 0; k < 4; k++) begin
      put({1'b0, k[1], k[0], 1'b1}); chk(refs, `REF_PRESET); chk(idx, k[1:0]);
    end
    restart(`SRC_TERMINAL, 5'h05, 4'h0);
    put(4'h1); chk(run, 1);
    put(4'h3); chk(fstop, 1); chk(run, 0);
    // Trip input is held closed at rest, then opened.
    restart(`SRC_TERMINAL, 5'h06, 4'h4);
    put(4'h5); chk(run, 1);
    put(4'h1); chk(trip, 1); chk(code_a, 1); chk(code_b, 0); chk(run, 0);
    put(4'h5); trip_clr = 1'b1; tick(4); trip_clr = 1'b0; tick(4); chk(trip, 0);
    fmt = 1'b1; put(4'h1); chk(code_b, 1); chk(code_a, 0);
    fmt = 1'b0;
    // Momentary start and stop contacts; stop is held closed at rest.
    restart(`SRC_TERMINAL, 5'h09, 4'h2);
    put(4'h3); put(4'h2); chk(run, 1);
    put(4'h0); put(4'h2); chk(run, 0);
    kp_need = 1'b1;
    restart(`SRC_KEYPAD_A, 5'h0E, 4'h0);
    put(4'h3); chk(run, 0);
    kp_go = 1'b1; tick(4); kp_go = 1'b0; tick(4); chk(run, 1);
    kp_need = 1'b0;
    restart(`SRC_KEYPAD_A, 5'h0E, 4'h0);
    put(4'h3); chk(run, 1);
    kp_halt = 1'b1; tick(4); chk(run, 0);
    kp_halt = 1'b0;
    restart(`SRC_KEYPAD_B, 5'h00, 4'h0);
    put(4'h3); chk(up, 1); chk(down, 0);
    put(4'h5); chk(up, 0); chk(down, 1);
    restart(`SRC_KEYPAD_A, 5'h02, 4'h0);
    put(4'h1); chk(refs, `REF_KEYPAD);
    put(4'h9); chk(refs, `REF_PRESET); chk(idx, 0);
    restart(4'h3, 5'h00, 4'h0); chk(refs, `REF_FIELDBUS); chk(en, 0);
    fb_go = 1'b1; tick(8); chk(run, 0);
    fb_go = 1'b0; put(4'h3); chk(en, 1); chk(refs, `REF_FIELDBUS);
    fb_go = 1'b1; tick(8); chk(run, 1);
    fb_go = 1'b0; fb_halt = 1'b1; tick(4); chk(run, 0);
    fb_halt = 1'b0;
    // Run contact already closed at power-on.
    auto_go = 1'b1; restart(`SRC_TERMINAL, 5'h00, 4'h1); chk(run, 1);
    auto_go = 1'b0; restart(`SRC_TERMINAL, 5'h00, 4'h1); chk(run, 0);
    conclude();
  end
  // The tests need well under two thousand cycles; this cuts a hang short.
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule // test_input_macro_decoder
bind input_macro_decoder input_macro_checker #(.FILTER_CYCLES(FILTER_CYCLES)) chk_u (
  .mclk(mclk), .rst_b(rst_b), .control_source(control_source), .input_macro(input_macro),
  .analog_two_format(analog_two_format), .trip_reset(trip_reset), .run_ff(run_ff),
  .fast_stop_ff(fast_stop_ff), .ref_select_ff(ref_select_ff), .ext_trip_ff(ext_trip_ff),
  .ext_trip_code_a_ff(ext_trip_code_a_ff), .ext_trip_code_b_ff(ext_trip_code_b_ff), .hw_enable_ff(hw_enable_ff));
